/* File: common/digit_io_regs.svh */
// register offsets, reset values, digit limit and timing for the digit display and switch scanner
// Summary of operation
// R1: display drives digit data while enabled
// R2: display accepts any 16-bit unsigned value
// R3: one to five displayed digits
// R4: decimal or hex digit conversion for display
// R5: latch and data polarity selectable separately
// R6: four data lines plus one latch per digit
// R7: display round bounded by per-digit step time
// R8: caller holds display enable for whole round
// R9: timer source shows present current value
// R10: switch result stored as word or bits
// R11: switch result is 16-bit, five digits max
// R12: decimal or hex switch digit interpretation
// R13: four consecutive data inputs from first input
// R14: one select output per switch digit
// R15: read time is step times digits plus one
// R16: caller holds read enable for whole read
// R17: place nibble, then pulse that digit's latch
// R18: select one digit, wait, then sample
// R19: input filter time is software configurable
`ifndef DIGIT_IO_REGS_SVH
`define DIGIT_IO_REGS_SVH

`define ADDR_W        4
`define REG_CTRL      4'h0
`define REG_DIGITS    4'h1
`define REG_PINS      4'h2
`define REG_SOURCE    4'h3
`define REG_FILTER    4'h4
`define REG_RESULT    4'h5
`define REG_STATUS    4'h6

`define CTRL_RESET    8'h30
`define DIGITS_RESET  6'h24
`define PINS_RESET    15'h0120
`define FILTER_RESET  8'h04
`define DIGITS_MAX    5

`define CLK_NS             10
`define MS_NS              1000000
`define SEVEN_SEGMENT_OUTPUT_GAP_MS        10
`define SEVEN_SEGMENT_OUTPUT_SCAN_LIMIT_MS 5
`define SEVEN_SEGMENT_OUTPUT_SLOW_SCANS    3
`define READ_EXTRA_MS      3
`define READ_SLOW_SCANS    2

`endif

/* File: common/digit_io_pkg.sv */
// types shared by the digit display and switch scanner
package digit_io_pkg;
    typedef struct packed {
        logic dest_bits;
        logic source_timer;
        logic data_phase_select;
        logic latch_phase_select;
        logic read_hex;
        logic seven_segment_output_hex;
        logic read_en;
        logic seven_segment_output_en;
    } ctrl_t;

    typedef struct packed {
        logic [2:0] read_digits;
        logic [2:0] seven_segment_output_digits;
    } digits_t;

    typedef struct packed {
        logic [4:0] first_in;
        logic [4:0] sel_first;
        logic [4:0] seven_segment_output_first;
    } pins_t;

    typedef enum logic [1:0] {SEVEN_SEGMENT_OUTPUT_IDLE, SEVEN_SEGMENT_OUTPUT_SETUP, SEVEN_SEGMENT_OUTPUT_STROBE} seven_segment_output_state_t;
    typedef enum logic [1:0] {SCAN_IDLE, SCAN_SELECT, SCAN_FINISH} scan_state_t;
endpackage

/* File: hdl/seg_display.sv */
// digit sequencer: one nibble and one latch pulse per displayed digit
`timescale 1ns/1ps
`include "digit_io_regs.svh"
module seg_display (
    input  logic        clk,
    input  logic        sys_rst,
    input  logic        enable,
    input  logic        hex,
    input  logic [2:0]  digits,
    input  logic [15:0] value,
    input  logic [31:0] step,
    output logic [3:0]  nibble,
    output logic [4:0]  latch,
    output logic        busy
);
    digit_io_pkg::seven_segment_output_state_t state, next_state;
    logic [2:0]  idx, next_idx;
    logic [31:0] cnt, next_cnt;
    logic [15:0] value_q, next_value_q;
    logic [3:0]  next_nibble;
    logic [4:0]  next_latch;

    // one decimal or hex digit of the held value
    function automatic logic [3:0] digit_of(input logic [15:0] v, input logic [2:0] i,
                                            input logic h);
        logic [15:0] scaled;
        scaled = v >> {i, 2'b00};
        if (!h) begin
            unique case (i)
                3'h0: scaled = v % 16'd10;
                3'h1: scaled = (v / 16'd10) % 16'd10;
                3'h2: scaled = (v / 16'd100) % 16'd10;
                3'h3: scaled = (v / 16'd1000) % 16'd10;
                default: scaled = v / 16'd10000;
            endcase
        end
        return scaled[3:0];
    endfunction

    // half the step sets up the nibble, the other half holds the latch
    always_comb begin
        next_state   = state;
        next_idx     = idx;
        next_cnt     = cnt + 32'h1;
        next_value_q = value_q;
        next_nibble  = nibble;
        next_latch   = latch;
        unique case (state)
            digit_io_pkg::SEVEN_SEGMENT_OUTPUT_IDLE: begin
                next_cnt = '0;
                if (enable) begin // R1
                    next_state   = digit_io_pkg::SEVEN_SEGMENT_OUTPUT_SETUP;
                    next_idx     = '0;
                    next_value_q = value; // R2
                end
            end
            digit_io_pkg::SEVEN_SEGMENT_OUTPUT_SETUP: begin
                next_nibble = digit_of(value_q, idx, hex); // R4
                if (cnt >= (step >> 1) - 32'h1) begin
                    next_state = digit_io_pkg::SEVEN_SEGMENT_OUTPUT_STROBE;
                    next_cnt   = '0;
                    next_latch = 5'(5'h1 << idx); // R17
                end
            end
            digit_io_pkg::SEVEN_SEGMENT_OUTPUT_STROBE: begin
                if (cnt >= step - (step >> 1) - 32'h1) begin // R7
                    next_latch = '0;
                    next_cnt   = '0;
                    next_state = digit_io_pkg::SEVEN_SEGMENT_OUTPUT_SETUP;
                    next_idx   = idx + 3'h1;
                    if (idx >= digits - 3'h1) begin // R3
                        next_idx     = '0;
                        next_value_q = value;
                        if (!enable) begin
                            next_state = digit_io_pkg::SEVEN_SEGMENT_OUTPUT_IDLE;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state   <= digit_io_pkg::SEVEN_SEGMENT_OUTPUT_IDLE;
            idx     <= '0;
            cnt     <= '0;
            value_q <= '0;
            nibble  <= '0;
            latch   <= '0;
        end else begin
            state   <= next_state;
            idx     <= next_idx;
            cnt     <= next_cnt;
            value_q <= next_value_q;
            nibble  <= next_nibble;
            latch   <= next_latch;
        end
    end

    assign busy = (state != digit_io_pkg::SEVEN_SEGMENT_OUTPUT_IDLE);

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    hex_nibble_a: assert property (hex && (|latch) |-> nibble == 4'(value_q >> {idx, 2'b00})) // R4
        else $error("hex digit on data lines does not match value");
    digit_limit_a: assert property ((|latch) |-> idx < digits) // R3
        else $error("latch pulsed beyond configured digit count");
endmodule

/* File: hdl/switch_scan.sv */
// switch scanner: selects each digit, waits, samples its nibble, builds the result
`timescale 1ns/1ps
`include "digit_io_regs.svh"
module switch_scan (
    input  logic        clk,
    input  logic        sys_rst,
    input  logic        enable,
    input  logic        hex,
    input  logic [2:0]  digits,
    input  logic [3:0]  sample,
    input  logic [31:0] step,
    output logic [4:0]  select,
    output logic [15:0] result,
    output logic        done,
    output logic        busy
);
    digit_io_pkg::scan_state_t state, next_state;
    logic [2:0]  idx, next_idx;
    logic [31:0] cnt, next_cnt;
    logic [20:0] acc, next_acc;
    logic [16:0] weight, next_weight;
    logic [4:0]  next_select;
    logic [15:0] next_result;
    logic        next_done;

    // one step per digit plus one closing step before the result is stored
    always_comb begin
        next_state  = state;
        next_idx    = idx;
        next_cnt    = cnt + 32'h1;
        next_acc    = acc;
        next_weight = weight;
        next_select = select;
        next_result = result;
        next_done   = 1'b0;
        unique case (state)
            digit_io_pkg::SCAN_IDLE: begin
                next_cnt = '0;
                if (enable) begin // R10
                    next_state  = digit_io_pkg::SCAN_SELECT;
                    next_idx    = '0;
                    next_acc    = '0;
                    next_weight = 17'h1;
                    next_select = 5'h1; // R14
                end
            end
            digit_io_pkg::SCAN_SELECT: begin
                if (cnt >= step - 32'h1) begin // R18
                    next_cnt    = '0;
                    next_acc    = acc + 21'(sample * weight);
                    next_weight = 17'(weight * (hex ? 17'h10 : 17'ha)); // R12
                    next_idx    = idx + 3'h1;
                    next_select = 5'(5'h1 << (idx + 3'h1));
                    if (idx >= digits - 3'h1) begin
                        next_state  = digit_io_pkg::SCAN_FINISH;
                        next_select = '0;
                    end
                end
            end
            digit_io_pkg::SCAN_FINISH: begin
                if (cnt >= step - 32'h1) begin // R15
                    next_state  = digit_io_pkg::SCAN_IDLE;
                    next_result = (acc > 21'h00ffff) ? 16'hffff : acc[15:0]; // R11
                    next_done   = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state  <= digit_io_pkg::SCAN_IDLE;
            idx    <= '0;
            cnt    <= '0;
            acc    <= '0;
            weight <= 17'h1;
            select <= '0;
            result <= '0;
            done   <= 1'b0;
        end else begin
            state  <= next_state;
            idx    <= next_idx;
            cnt    <= next_cnt;
            acc    <= next_acc;
            weight <= next_weight;
            select <= next_select;
            result <= next_result;
            done   <= next_done;
        end
    end

    assign busy = (state != digit_io_pkg::SCAN_IDLE);
endmodule

/* File: hdl/digit_display_and_switch_scanner.sv */
// top of the digit display driver and digital switch scanner with its register port
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
`include "digit_io_regs.svh"
module digit_display_and_switch_scanner #(
    parameter int unsigned MS_CYCLES   = `MS_NS / `CLK_NS,
    parameter int unsigned SCAN_CYCLES = `MS_NS / `CLK_NS
) (
    input  logic                 clk,
    input  logic                 sys_rst,
    input  logic [`ADDR_W-1:0]   reg_addr,
    input  logic [15:0]          reg_wdata,
    input  logic                 reg_write,
    input  logic                 reg_read,
    output logic [15:0]          reg_rdata,
    input  logic [15:0]          timer_current_value,
    input  logic [31:0]          in_pins,
    output logic [31:0]          out_pins,
    output logic [15:0]          switch_bits
);
    // per-digit display step: slow scans take three scans, fast ones the gap plus one scan
    localparam int unsigned SEVEN_SEGMENT_OUTPUT_STEP =
        (SCAN_CYCLES < `SEVEN_SEGMENT_OUTPUT_SCAN_LIMIT_MS * MS_CYCLES) ?
        `SEVEN_SEGMENT_OUTPUT_GAP_MS * MS_CYCLES + SCAN_CYCLES : `SEVEN_SEGMENT_OUTPUT_SLOW_SCANS * SCAN_CYCLES;
    localparam int unsigned READ_SCAN_STEP = `READ_SLOW_SCANS * SCAN_CYCLES;

    digit_io_pkg::ctrl_t   ctrl, next_ctrl;
    digit_io_pkg::digits_t digits, next_digits;
    digit_io_pkg::pins_t   pins, next_pins;
    logic [15:0] source, next_source;
    logic [7:0]  filter, next_filter;
    logic [15:0] result, next_result;
    logic [15:0] next_switch_bits;
    logic        result_valid, next_result_valid;
    logic [15:0] next_rdata;
    logic [31:0] read_step, next_read_step;
    logic [31:0] filter_step;

    logic [31:0] in_meta;
    logic [31:0] in_sync;
    logic [31:0] next_out;

    logic [15:0] seven_segment_output_value;
    logic [3:0]  nibble;
    logic [4:0]  latch;
    logic        seven_segment_output_busy;
    logic [4:0]  select;
    logic [15:0] scan_result;
    logic        scan_done;
    logic        scan_busy;
    logic [3:0]  sample;

    logic [4:0]  seven_segment_output_mask;
    logic [4:0]  latch_line;
    logic [3:0]  data_line;
    logic [8:0]  seven_segment_output_field;

    // digit counts outside one to five are pulled into range on write
    function automatic logic [2:0] clamp_digits(input logic [2:0] d);
        logic [2:0] c;
        c = d;
        if (d == 3'h0) begin
            c = 3'h1;
        end else if (d > 3'(`DIGITS_MAX)) begin
            c = 3'(`DIGITS_MAX);
        end
        return c;
    endfunction

    // register writes, result capture and the read-data register
    always_comb begin
        next_ctrl         = ctrl;
        next_digits       = digits;
        next_pins         = pins;
        next_source       = source;
        next_filter       = filter;
        next_result       = result;
        next_switch_bits  = switch_bits;
        next_result_valid = result_valid;
        next_rdata        = '0;
        if (reg_write) begin
            unique case (reg_addr)
                `REG_CTRL:   next_ctrl = reg_wdata[7:0];
                `REG_DIGITS: begin
                    next_digits.seven_segment_output_digits = clamp_digits(reg_wdata[2:0]); // R3
                    next_digits.read_digits = clamp_digits(reg_wdata[5:3]);
                end
                `REG_PINS:   next_pins = reg_wdata[14:0];
                `REG_SOURCE: next_source = reg_wdata; // R2
                `REG_FILTER: next_filter = reg_wdata[7:0]; // R19
                default: ;
            endcase
        end
        if (reg_read) begin
            unique case (reg_addr)
                `REG_CTRL:   next_rdata = {8'h0, ctrl};
                `REG_DIGITS: next_rdata = {10'h0, digits};
                `REG_PINS:   next_rdata = {1'b0, pins};
                `REG_SOURCE: next_rdata = source;
                `REG_FILTER: next_rdata = {8'h0, filter};
                `REG_RESULT: next_rdata = result;
                `REG_STATUS: next_rdata = {13'h0, result_valid, scan_busy, seven_segment_output_busy};
                default:     next_rdata = '0;
            endcase
            // reading the result clears its valid flag
            if (reg_addr == `REG_RESULT) begin
                next_result_valid = 1'b0;
            end
        end
        if (scan_done) begin
            // a new result in the clearing cycle keeps the flag set
            next_result_valid = 1'b1;
            if (ctrl.dest_bits) begin
                next_switch_bits = scan_result; // R10
            end else begin
                next_result = scan_result; // R10
            end
        end
    end

    // read step is the longer of two scans and the filter plus settling time
    always_comb begin
        filter_step    = (32'(filter) + 32'(`READ_EXTRA_MS)) * MS_CYCLES; // R19
        next_read_step = (READ_SCAN_STEP > filter_step) ? READ_SCAN_STEP : filter_step; // R15
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl         <= `CTRL_RESET;
            digits       <= `DIGITS_RESET;
            pins         <= `PINS_RESET;
            source       <= '0;
            filter       <= `FILTER_RESET;
            result       <= '0;
            switch_bits  <= '0;
            result_valid <= 1'b0;
            reg_rdata    <= '0;
            read_step    <= '0;
        end else begin
            ctrl         <= next_ctrl;
            digits       <= next_digits;
            pins         <= next_pins;
            source       <= next_source;
            filter       <= next_filter;
            result       <= next_result;
            switch_bits  <= next_switch_bits;
            result_valid <= next_result_valid;
            reg_rdata    <= next_rdata;
            read_step    <= next_read_step;
        end
    end

    // switch data lines come from another domain, so two flops before use
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_meta <= '0;
            in_sync <= '0;
        end else begin
            in_meta <= in_pins;
            in_sync <= in_meta;
        end
    end

    // timer source shows its live count, never its preset
    assign seven_segment_output_value = ctrl.source_timer ? timer_current_value : source; // R9

    seg_display u_seven_segment_output (
        .clk     (clk),
        .sys_rst (sys_rst),
        .enable  (ctrl.seven_segment_output_en),
        .hex     (ctrl.seven_segment_output_hex),
        .digits  (digits.seven_segment_output_digits),
        .value   (seven_segment_output_value),
        .step    (SEVEN_SEGMENT_OUTPUT_STEP),
        .nibble  (nibble),
        .latch   (latch),
        .busy    (seven_segment_output_busy)
    );

    // four shared data inputs picked from the first configured input
    assign sample = 4'(in_sync >> pins.first_in); // R13

    switch_scan u_scan (
        .clk     (clk),
        .sys_rst (sys_rst),
        .enable  (ctrl.read_en),
        .hex     (ctrl.read_hex),
        .digits  (digits.read_digits),
        .sample  (sample),
        .step    (read_step),
        .select  (select),
        .result  (scan_result),
        .done    (scan_done),
        .busy    (scan_busy)
    );

    // polarity and digit mask; unused latch positions stay free for other use
    always_comb begin
        seven_segment_output_mask  = 5'((6'h1 << digits.seven_segment_output_digits) - 6'h1);
        latch_line = ctrl.latch_phase_select ? latch : ~latch; // R5
        data_line  = ctrl.data_phase_select ? nibble : ~nibble; // R5
        seven_segment_output_field = {latch_line & seven_segment_output_mask, data_line}; // R6
        // blocks placed past the top of the bank are cut off there
        next_out   = (32'(seven_segment_output_field) << pins.seven_segment_output_first) |
                     (32'(select) << pins.sel_first); // R14
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_pins <= '0;
        end else begin
            out_pins <= next_out;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    read_data_a: assert property (reg_read && reg_addr == `REG_SOURCE |=> reg_rdata == $past(source))
        else $error("read data does not show the source register");
    unmapped_zero_a: assert property (reg_read && reg_addr > `REG_STATUS |=> reg_rdata == 16'h0)
        else $error("unmapped read returned nonzero");
    latch_rest_a: assert property (!seven_segment_output_busy |-> latch_line == {5{~ctrl.latch_phase_select}}) // R5
        else $error("idle latch lines not at inactive level");
    latch_onehot_a: assert property ($onehot0(latch)) // R17
        else $error("more than one latch line active");
    data_hold_a: assert property ((|latch) && $past(|latch) |-> $stable(nibble)) // R17
        else $error("data lines moved during latch pulse");
    select_onehot_a: assert property ($onehot0(select)) // R18
        else $error("more than one digit select active");
    finish_slot_a: assert property (scan_done |-> select == 5'h0 && $past(select) == 5'h0) // R15
        else $error("result stored while a digit was still selected");
    result_store_a: assert property (scan_done && !ctrl.dest_bits |=> result == $past(scan_result)) // R10
        else $error("result word not updated on completion");
    bits_store_a: assert property (scan_done && ctrl.dest_bits |=> switch_bits == $past(scan_result)) // R10
        else $error("result bits not updated on completion");
    valid_set_a: assert property (scan_done |=> result_valid) // R10
        else $error("result valid flag lost on completion");
    out_map_a: assert property (pins.seven_segment_output_first == 5'h0 && pins.sel_first > 5'h8 |=>
                                out_pins[3:0] == $past(data_line)) // R6
        else $error("data lines not at first display output");

    full_round_c: cover property ($fell(latch[4]));
    scan_done_c: cover property (scan_done && ctrl.read_hex);
    hex_show_c: cover property (ctrl.seven_segment_output_hex && (|latch));
    clear_race_c: cover property (scan_done && reg_read && reg_addr == `REG_RESULT);
endmodule

/* File: testbench/panel_model.sv */
// partner model: latching digit display units and thumbwheel switches on the pin banks
`timescale 1ns/1ps
module panel_model (
    input  wire logic        clk,
    input  wire logic [31:0] out_pins,
    input  wire logic        lat_high,
    input  wire logic        dat_high,
    input  wire logic        clear,
    input  wire logic [19:0] sw,
    output logic      [31:0] in_pins,
    output logic      [19:0] shown,
    output logic      [4:0]  hits
);
    logic [4:0]  lat_q = 5'h00;
    logic [31:0] noise = 32'h1234abcd;
    logic [4:0]  lat;
    logic [4:0]  sel;
    // pins 0..3 carry the digit code, pins 4..8 the per-digit latches
    assign lat = out_pins[8:4] ^ {5{~lat_high}};
    assign sel = out_pins[13:9];
    // a display unit takes its digit when its latch turns active
    always @(posedge clk) begin
        lat_q <= lat;
        noise <= noise * 32'h0019660d + 32'h3c6ef35f;
        for (int i = 0; i < 5; i++) begin
            if (lat[i] && !lat_q[i]) begin
                shown[i*4 +: 4] <= out_pins[3:0] ^ {4{~dat_high}};
                hits[i]         <= 1'b1;
            end
        end
        if (clear) begin
            shown <= 20'h00000;
            hits  <= 5'h00;
        end
    end
    // an unselected switch bus floats, so it shows a changing pattern
    always_comb begin
        in_pins = noise;
        for (int i = 0; i < 5; i++) begin
            if (sel == (5'h01 << i)) begin
                in_pins[3:0] = sw[i*4 +: 4];
            end
        end
    end
endmodule

/* File: testbench/tb_digit_display_and_switch_scanner.sv */
// self-checking bench for the digit display driver and switch scanner
`timescale 1ns/1ps
module tb_digit_display_and_switch_scanner;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic [15:0] timer_current_value = 16'h0000;
    logic [31:0] in_pins;
    logic [31:0] out_pins;
    logic [15:0] switch_bits;
    logic        lat_high = 1'b1;
    logic        dat_high = 1'b1;
    logic        clear = 1'b0;
    logic [19:0] sw = 20'h00000;
    logic [19:0] shown;
    logic [4:0]  hits;
    int          mismatches = 0;
    int          n_compared = 0;

    // short ms and scan so a display step is 42 cycles and a read step 16
    digit_display_and_switch_scanner #(.MS_CYCLES(4), .SCAN_CYCLES(2))
        i_digit_display_and_switch_scanner (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .timer_current_value(timer_current_value), .in_pins(in_pins),
        .out_pins(out_pins), .switch_bits(switch_bits));
    panel_model i_panel_model (.clk(clk), .out_pins(out_pins), .lat_high(lat_high),
        .dat_high(dat_high), .clear(clear), .sw(sw), .in_pins(in_pins),
        .shown(shown), .hits(hits));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic end_sim;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    function automatic logic [3:0] dig(input logic [15:0] v, input int i, input logic hx);
        logic [31:0] p;
        p = 1;
        for (int j = 0; j < i; j++) p = p * 10;
        // a 16-bit value has no fifth hex nibble, so that digit shows zero
        if (hx) return 4'(32'(v) >> (4 * i));
        if (i == 4) return 4'(v / 10000);
        return 4'((v / p) % 10);
    endfunction

    function automatic logic [15:0] swval(input logic [19:0] s, input int n, input logic hx);
        logic [31:0] acc;
        acc = 0;
        for (int i = n - 1; i >= 0; i--) acc = acc * (hx ? 16 : 10) + s[i*4 +: 4];
        return (acc > 32'hffff) ? 16'hffff : acc[15:0];
    endfunction

    // one display round; enable held for the whole processing time
    task automatic seven_segment_output_run(input logic [15:0] v, input logic [2:0] d, input logic hx,
                            input logic tmr, input logic lp, input logic dp);
        logic [15:0] c;
        c = {8'h00, 1'b0, tmr, dp, lp, 1'b0, hx, 2'b00};
        timer_current_value <= v;
        lat_high <= lp;
        dat_high <= dp;
        wr(4'h1, {10'h000, 3'd4, d});
        wr(4'h3, tmr ? ~v : v);
        wr(4'h0, c);
        repeat (3) @(posedge clk);
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
        wr(4'h0, c | 16'h0001);
        repeat (42 * d + 4) @(posedge clk);
        wr(4'h0, c);
        for (int i = 0; i < d; i++) chk(16'(shown[i*4 +: 4]), 16'(dig(v, i, hx)));
        chk(16'(hits), 16'((1 << d) - 1));
        repeat (220) @(posedge clk);
    endtask

    // one switch read into the word register or the bit bank
    task automatic sw_run(input logic [19:0] s, input logic [2:0] d, input logic hx,
                          input logic bits);
        logic [15:0] c;
        logic [15:0] r;
        c = {8'h00, bits, 3'b011, hx, 3'b000};
        sw <= s;
        // reading the word first clears the valid flag, so this read must set it again
        rd(4'h5, r);
        wr(4'h1, {10'h000, d, 3'd1});
        wr(4'h4, 16'h0001);
        wr(4'h0, c | 16'h0002);
        repeat (16 * (d + 1) + 5) @(posedge clk);
        wr(4'h0, c);
        if (bits) begin
            chk(switch_bits, swval(s, d, hx));
        end else begin
            rd(4'h6, r);
            chk(r & 16'h0004, 16'h0004);
            rd(4'h5, r);
            chk(r, swval(s, d, hx));
        end
        repeat (110) @(posedge clk);
    endtask

    // two live digit selects would short the switch bus
    always @(posedge clk) begin
        if (!sys_rst && $countones(out_pins[13:9]) > 1) begin
            chk(16'(out_pins[13:9]), 16'h0000);
        end
    end

    // about six times the expected length of all scenarios
    initial begin
        #300_000;
        mismatches++;
        end_sim();
    end

    initial begin
        logic [15:0] r;
        logic [19:0] s;
        logic        hx;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        void'($urandom(30));
        rd(4'h0, r);
        chk(r, 16'h0030);
        rd(4'h1, r);
        chk(r, 16'h0024);
        rd(4'h2, r);
        chk(r, 16'h0120);
        rd(4'h4, r);
        chk(r, 16'h0004);
        rd(4'h7, r);
        chk(r, 16'h0000);
        seven_segment_output_run(16'hffff, 3'd5, 1'b1, 1'b0, 1'b1, 1'b1);
        seven_segment_output_run(16'hffff, 3'd5, 1'b0, 1'b1, 1'b0, 1'b0);
        seven_segment_output_run(16'h0000, 3'd1, 1'b0, 1'b0, 1'b0, 1'b1);
        for (int k = 0; k < 6; k++) begin
            seven_segment_output_run(16'($urandom), 3'(1 + $urandom % 5), 1'($urandom),
                     1'($urandom), 1'($urandom), 1'($urandom));
        end
        sw_run(20'h99999, 3'd5, 1'b0, 1'b0);
        sw_run(20'h0fedc, 3'd4, 1'b1, 1'b1);
        for (int k = 0; k < 6; k++) begin
            hx = 1'($urandom);
            for (int i = 0; i < 5; i++) s[i*4 +: 4] = hx ? 4'($urandom) : 4'($urandom % 10);
            sw_run(s, 3'(1 + $urandom % 5), hx, 1'($urandom));
        end
        end_sim();
    end
endmodule
